// File: include/fpc_pkg.sv
// shared constants for the flash program/erase control block
package fpc_pkg;
  localparam logic [7:0] FPC_OFS_CTRL = 8'hF0;
  localparam logic [7:0] FPC_OFS_KEY = 8'hF1;
  localparam logic [7:0] FPC_OFS_SECH = 8'hF2;
  localparam logic [7:0] FPC_OFS_SECL = 8'hF3;
  localparam logic [3:0] FPC_MODE_PROG = 4'h5;
  localparam logic [3:0] FPC_MODE_ERASE = 4'hA;
  localparam logic [3:0] FPC_MODE_LOCK = 4'h6;
  localparam logic [7:0] FPC_USER_KEY = 8'hA5;
  localparam int FPC_MODE_MSB = 7;
  localparam int FPC_MODE_LSB = 4;
  localparam int FPC_FAIL_BIT = 3;
  localparam int FPC_START_BIT = 0;
  localparam int FPC_SECL_BIT = 7;
  localparam logic [7:0] FPC_CTRL_RST = 8'h00;
  localparam logic [7:0] FPC_SECH_RST = 8'h00;
  localparam logic [7:0] FPC_SECL_RST = 8'h00;
  localparam logic [7:0] FPC_KEY_RST = 8'h00;
  typedef enum logic [1:0] {
    FPC_IDLE = 2'b01,
    FPC_BUSY = 2'b10
  } fpc_state_e;
endpackage : fpc_pkg

// File: src/fpc_reg8.sv
// one software-writable register with reset value
module fpc_reg8 import fpc_pkg::*; #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    q_nxt = wr_en ? wdata : q_r;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_r <= RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : fpc_reg8

// File: src/fpc_flash_ctrl.sv
// flash program/erase/hard-lock control registers and sequencer
// Behaviour
// - control bits 7..4 pick program 0101, erase 1010, lock 0110; else none
// - writing one to control bit 0 starts; bit clears itself on completion
// - sector high register gives sector address bits 15..8
// - sector pointer is 16 bits: high register above low register
// - only low register bit 7 enters the pointer, as bit 7; pointer bits 6..0 are zero
// - user programming allowed only while key register holds 10100101
// - any other key value disables user programming; program/erase refused
module fpc_flash_ctrl import fpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic flash_op_start,
  output logic [3:0] flash_op_mode,
  output logic [15:0] flash_sector_addr,
  input wire logic flash_op_done,
  input wire logic flash_erase_fail,
  output logic user_prog_enable
);
  fpc_state_e state_r;
  fpc_state_e state_nxt;
  logic [3:0] mode_r;
  logic [3:0] mode_nxt;
  logic start_r;
  logic start_nxt;
  logic fail_r;
  logic fail_nxt;
  logic op_start_r;
  logic op_start_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] sech_q;
  logic [7:0] secl_q;
  logic [7:0] key_q;
  logic idle;
  logic wr_ctrl;
  logic mode_valid;
  logic mode_needs_key;
  logic key_ok;
  logic accept;

  assign idle = (state_r == FPC_IDLE);
  // a running operation keeps its mode and sector stable
  assign wr_ctrl = reg_wr && idle && (reg_addr == FPC_OFS_CTRL);
  assign key_ok = (key_q == FPC_USER_KEY);
  assign user_prog_enable = key_ok;

  always_comb begin
    mode_valid = 1'b0;
    mode_needs_key = 1'b0;
    case (reg_wdata[FPC_MODE_MSB:FPC_MODE_LSB])
      FPC_MODE_PROG: begin
        mode_valid = 1'b1;
        mode_needs_key = 1'b1;
      end
      FPC_MODE_ERASE: begin
        mode_valid = 1'b1;
        mode_needs_key = 1'b1;
      end
      FPC_MODE_LOCK: begin
        mode_valid = 1'b1;
      end
      default: begin
        mode_valid = 1'b0;
      end
    endcase
  end

  // refused starts never set the start bit, so software sees it at zero
  assign accept = wr_ctrl && reg_wdata[FPC_START_BIT] && mode_valid &&
                  (key_ok || !mode_needs_key);

  fpc_reg8 #(.WIDTH(8), .RESET(FPC_SECH_RST)) u_sech (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(reg_wr && idle && (reg_addr == FPC_OFS_SECH)),
    .wdata(reg_wdata),
    .q(sech_q)
  );

  fpc_reg8 #(.WIDTH(8), .RESET(FPC_SECL_RST)) u_secl (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(reg_wr && idle && (reg_addr == FPC_OFS_SECL)),
    .wdata(reg_wdata),
    .q(secl_q)
  );

  fpc_reg8 #(.WIDTH(8), .RESET(FPC_KEY_RST)) u_key (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(reg_wr && (reg_addr == FPC_OFS_KEY)),
    .wdata(reg_wdata),
    .q(key_q)
  );

  // sector granule is 128 bytes, low seven pointer bits forced to zero
  assign flash_sector_addr = {sech_q, secl_q[FPC_SECL_BIT],
                              7'h00};

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    start_nxt = start_r;
    fail_nxt = fail_r;
    op_start_nxt = 1'b0;
    case (state_r)
      FPC_IDLE: begin
        if (wr_ctrl) begin
          mode_nxt = reg_wdata[FPC_MODE_MSB:FPC_MODE_LSB];
        end
        if (accept) begin
          start_nxt = 1'b1;
          op_start_nxt = 1'b1;
          state_nxt = FPC_BUSY;
        end
      end
      FPC_BUSY: begin
        if (flash_op_done) begin
          start_nxt = 1'b0;
          state_nxt = FPC_IDLE;
          if (mode_r == FPC_MODE_ERASE) begin
            fail_nxt = flash_erase_fail;
          end
        end
      end
      default: begin
        state_nxt = FPC_IDLE;
        start_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= FPC_IDLE;
      mode_r <= FPC_CTRL_RST[FPC_MODE_MSB:FPC_MODE_LSB];
      start_r <= FPC_CTRL_RST[FPC_START_BIT];
      fail_r <= FPC_CTRL_RST[FPC_FAIL_BIT];
      op_start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      start_r <= start_nxt;
      fail_r <= fail_nxt;
      op_start_r <= op_start_nxt;
    end
  end

  assign flash_op_start = op_start_r;
  assign flash_op_mode = mode_r;

  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      if (reg_addr == FPC_OFS_CTRL) begin
        rdata_nxt = {mode_r, fail_r, 2'b00, start_r};
      end else if (reg_addr == FPC_OFS_KEY) begin
        rdata_nxt = key_q;
      end else if (reg_addr == FPC_OFS_SECH) begin
        rdata_nxt = sech_q;
      end else if (reg_addr == FPC_OFS_SECL) begin
        rdata_nxt = secl_q;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  sequence ctrl_start_write_s;
    reg_wr && (reg_addr == FPC_OFS_CTRL) && idle && reg_wdata[0];
  endsequence

  sequence op_launched_s;
    flash_op_start && start_r && (state_r == FPC_BUSY);
  endsequence

  sequence op_ending_s;
    (state_r == FPC_BUSY) && flash_op_done && start_r;
  endsequence

  sequence op_waiting_s;
    (state_r == FPC_BUSY) && !flash_op_done;
  endsequence

  start_launch_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_start_write_s ##0 accept |=> op_launched_s)
    else $error("accepted start did not launch operation");

  mode_decode_a: assert property (@(posedge sys_clk) disable iff (rst)
    flash_op_start |-> (flash_op_mode == FPC_MODE_PROG ||
      flash_op_mode == FPC_MODE_ERASE || flash_op_mode == FPC_MODE_LOCK))
    else $error("operation launched with invalid mode");

  bad_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_start_write_s ##0 !mode_valid |=> !start_r && !flash_op_start)
    else $error("invalid mode was started");

  key_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    flash_op_start && (flash_op_mode != FPC_MODE_LOCK) |-> $past(key_ok))
    else $error("program or erase without enabling key");

  key_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && (reg_addr == FPC_OFS_KEY) |=>
      user_prog_enable == ($past(reg_wdata) == FPC_USER_KEY))
    else $error("user programming enable does not follow key");

  done_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    op_ending_s |=> !start_r && idle)
    else $error("start bit not cleared on completion");

  busy_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    op_waiting_s |=> start_r && !idle && $stable(flash_op_mode))
    else $error("start bit or mode changed during operation");

  erase_fail_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == FPC_BUSY) && flash_op_done && (mode_r == FPC_MODE_ERASE) |=>
      fail_r == $past(flash_erase_fail) ##1
      (reg_rdata[3] == fail_r || !$past(reg_rd)))
    else $error("erase failure flag wrong");

  sector_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && idle && (reg_addr == FPC_OFS_SECL) |=>
      flash_sector_addr[7:0] == {$past(reg_wdata[7]), 7'h00})
    else $error("sector low bits wrong");

  sector_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && idle && (reg_addr == FPC_OFS_SECH) |=>
      flash_sector_addr[15:8] == $past(reg_wdata))
    else $error("sector high byte wrong");
endmodule : fpc_flash_ctrl

// File: verification/fpc_flash_model.sv
// flash array stand-in: answers each start after a chosen delay
module fpc_flash_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flash_op_start,
  input wire logic [7:0] delay,
  input wire logic fail_in,
  output logic flash_op_done,
  output logic flash_erase_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else if (flash_op_start) begin
      cnt_r <= delay;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign flash_op_done = (cnt_r == 8'h01);
  // fail is only meaningful with done; show the inverse otherwise
  assign flash_erase_fail = flash_op_done ? fail_in : ~fail_in;
endmodule : fpc_flash_model

// File: verification/test_flash_program_erase_control.sv
// self-checking bench for the flash program/erase control block
module test_flash_program_erase_control import fpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, reg_wr, reg_rd, flash_op_start, flash_op_done;
  logic flash_erase_fail, user_prog_enable, fail_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, delay, rd_v;
  logic [3:0] flash_op_mode;
  logic [15:0] flash_sector_addr;
  int n_errors, compares;
  fpc_flash_ctrl DUT (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .flash_op_start, .flash_op_mode,
    .flash_sector_addr, .flash_op_done, .flash_erase_fail,
    .user_prog_enable);
  fpc_flash_model flash (.sys_clk, .rst, .flash_op_start, .delay,
    .fail_in, .flash_op_done, .flash_erase_fail);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask : rd
  task automatic test_reset();
    check(16'(user_prog_enable), 16'h0000);
    // includes one unmapped address past the last register
    for (int a = 8'hF0; a < 8'hF5; a++) begin
      rd(8'(a));
      check(16'(rd_v), 16'h0000);
    end
  endtask : test_reset
  task automatic test_key();
    wr(FPC_OFS_KEY, 8'hA5);
    check(16'(user_prog_enable), 16'h0001);
    rd(FPC_OFS_KEY);
    check(16'(rd_v), 16'h00A5);
    wr(FPC_OFS_KEY, 8'h5A);
    check(16'(user_prog_enable), 16'h0000);
    wr(FPC_OFS_CTRL, 8'h51);
    check(16'(flash_op_start), 16'h0000);
    rd(FPC_OFS_CTRL);
    check(16'(rd_v), 16'h0050);
    wr(FPC_OFS_CTRL, 8'hA1);
    check(16'(flash_op_start), 16'h0000);
  endtask : test_key
  task automatic test_sector();
    wr(FPC_OFS_SECH, 8'hAB);
    wr(FPC_OFS_SECL, 8'hFF);
    check(flash_sector_addr, 16'hAB80);
    rd(FPC_OFS_SECL);
    check(16'(rd_v), 16'h00FF);
    wr(FPC_OFS_SECL, 8'h7F);
    check(flash_sector_addr, 16'hAB00);
  endtask : test_sector
  task automatic run_op(input logic [3:0] m, input logic f,
                        input logic [7:0] d);
    int i;
    delay <= d;
    fail_in <= f;
    wr(FPC_OFS_CTRL, {m, 4'h1});
    check(16'(flash_op_start), 16'h0001);
    check(16'(flash_op_mode), 16'(m));
    // first read is sampled before done can reach the sequencer
    rd(FPC_OFS_CTRL);
    check(16'(rd_v[FPC_START_BIT]), 16'h0001);
    for (i = 0; i < 40; i++) begin
      rd(FPC_OFS_CTRL);
      if (rd_v[0] === 1'b0) break;
    end
    if (i == 40) begin
      n_errors++;
      tally_and_finish();
    end
    check(16'(rd_v), 16'({m, f, 3'h0}));
  endtask : run_op
  task automatic test_ops();
    wr(FPC_OFS_KEY, FPC_USER_KEY);
    run_op(FPC_MODE_PROG, 1'b0, 8'h01);
    run_op(FPC_MODE_LOCK, 1'b0, 8'h06);
    run_op(FPC_MODE_ERASE, 1'b1, 8'h03);
    run_op(FPC_MODE_ERASE, 1'b0, 8'h09);
    wr(FPC_OFS_CTRL, 8'h31);
    check(16'(flash_op_start), 16'h0000);
    rd(FPC_OFS_CTRL);
    check(16'(rd_v), 16'h0030);
  endtask : test_ops
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    delay = 8'h01;
    fail_in = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_key();
    test_sector();
    test_ops();
    tally_and_finish();
  end
endmodule : test_flash_program_erase_control
